/* design/vrc_pkg.sv */
// Purpose: constants for the voltage reference control block
// Assumes: 100 MHz system clock, 8-bit special-function bus
// Notes: one control register, upper four bits unused
package vrc_pkg;

  // special-function address and reset value
  localparam logic [7:0] REF_CTRL_ADDR = 8'hD1;
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  // bits that hold state; the rest read as zero
  localparam logic [7:0] REF_CTRL_MASK = 8'h0F;

  // field positions
  localparam int BIT_REF_BUFFER = 0;
  localparam int BIT_BIAS_GEN = 1;
  localparam int BIT_TEMP_SENSOR = 2;
  localparam int BIT_SOURCE_SEL = 3;
  localparam int BIT_P0_PIN7 = 7;

  // source select encodings
  localparam logic SRC_PIN_OR_INTERNAL = 1'b0;
  localparam logic SRC_SUPPLY = 1'b1;

  // port 0 pin 7 setup needed for an external reference
  localparam logic P0_ANALOG_MODE = 1'b0;
  localparam logic P0_SKIPPED = 1'b1;

  // reference turn-on wait, least time, rounded up to whole cycles
  localparam int CLK_MHZ = 100;
  localparam int VREF_TURN_ON_NS = 20000;
  localparam int VREF_TURN_ON_CYC_RAW = (VREF_TURN_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int VREF_TURN_ON_CYC = (VREF_TURN_ON_CYC_RAW < 1) ? 1 : VREF_TURN_ON_CYC_RAW;
  localparam int SETTLE_W = 12;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(VREF_TURN_ON_CYC - 1);

endpackage

/* design/vrc_sfr_port.sv */
// Purpose: address decode and read-data register for the control register
// Assumes: one-cycle strobes, synchronous to clk
// Notes: read data is registered and holds until the next read
`timescale 1ns/1ns
module vrc_sfr_port (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // special-function bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // register side
  input wire logic [7:0] reg_value,
  output logic wr_hit
);

  logic rd_hit;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  assign wr_hit = sfr_wr && (sfr_addr == vrc_pkg::REF_CTRL_ADDR);
  assign rd_hit = sfr_rd && (sfr_addr == vrc_pkg::REF_CTRL_ADDR);
  assign sfr_rdata = rdata_r;

  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd) begin
      // unmapped address reads zero
      rdata_nxt = rd_hit ? (reg_value & vrc_pkg::REF_CTRL_MASK) : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule // vrc_sfr_port

/* design/vrc_top.sv */
// Purpose: voltage reference and bias control register with effective enables
// Assumes: all inputs synchronous to clk; peripheral enables are levels
// Notes: every output is registered, so enables follow peripheral inputs by one cycle and register writes by two
//
// Behaviour
// - source select picks pin/internal or supply
// - converter or oscillator forces bias generator on
// - bias bit turns bias generator on manually
// - reference, sensor or multiplier force reference bias
// - sensor bit enables sensor; off means invalid
// - upper four bits read zero, ignore writes
`timescale 1ns/1ns
module vrc_top (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // special-function bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // dependent peripheral enables
  input wire logic adc_enable,
  input wire logic int_osc_enable,
  input wire logic clk_mult_enable,
  // port 0 configuration seen from outside
  input wire logic [7:0] port0_input_mode,
  input wire logic [7:0] port0_crossbar_skip,
  // analog controls
  output logic ref_source_select,
  output logic ref_buffer_enable,
  output logic temp_sensor_enable,
  output logic bias_gen_enable,
  output logic ref_bias_enable,
  // status
  output logic ref_ready,
  output logic temp_data_valid,
  output logic vref_pin_cfg_err
);

  // control register group
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic wr_hit;

  // effective enable group
  logic src_sel_r;
  logic src_sel_nxt;
  logic buf_en_r;
  logic buf_en_nxt;
  logic temp_en_r;
  logic temp_en_nxt;
  logic bias_en_r;
  logic bias_en_nxt;
  logic ref_bias_r;
  logic ref_bias_nxt;

  // settle and status group
  typedef enum logic [1:0] {VRC_REF_OFF, VRC_REF_SETTLE, VRC_REF_READY} vrc_ref_state_t;
  vrc_ref_state_t ref_state_r;
  vrc_ref_state_t ref_state_nxt;
  logic [vrc_pkg::SETTLE_W-1:0] settle_cnt_r;
  logic [vrc_pkg::SETTLE_W-1:0] settle_cnt_nxt;
  logic ready_r;
  logic ready_nxt;
  logic temp_valid_r;
  logic temp_valid_nxt;
  logic pin_err_r;
  logic pin_err_nxt;

  // helper: one field of the control register
  function automatic logic ctrl_bit(input logic [7:0] value, input int pos);
    ctrl_bit = value[pos];
  endfunction

  // helper: reference voltage taken from pin 7 by an outside source
  function automatic logic uses_external_ref(input logic [7:0] value);
    uses_external_ref = (ctrl_bit(value, vrc_pkg::BIT_SOURCE_SEL) ==
                         vrc_pkg::SRC_PIN_OR_INTERNAL) &&
                        !ctrl_bit(value, vrc_pkg::BIT_REF_BUFFER);
  endfunction

  // bus decode and readback
  vrc_sfr_port u_port (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata),
    .reg_value(ctrl_r),
    .wr_hit(wr_hit)
  );

  // control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_hit) begin
      // unused upper bits never store
      ctrl_nxt = sfr_wdata & vrc_pkg::REF_CTRL_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= vrc_pkg::REF_CTRL_RESET;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // effective enables
  always_comb begin
    src_sel_nxt = ctrl_bit(ctrl_r, vrc_pkg::BIT_SOURCE_SEL);
    buf_en_nxt = ctrl_bit(ctrl_r, vrc_pkg::BIT_REF_BUFFER);
    temp_en_nxt = ctrl_bit(ctrl_r, vrc_pkg::BIT_TEMP_SENSOR);
    bias_en_nxt = ctrl_bit(ctrl_r, vrc_pkg::BIT_BIAS_GEN);
    if (adc_enable || int_osc_enable) begin
      bias_en_nxt = 1'b1;
    end
    // no register bit: purely the users of the reference bias
    ref_bias_nxt = buf_en_nxt || temp_en_nxt || clk_mult_enable;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_sel_r <= vrc_pkg::SRC_PIN_OR_INTERNAL;
      buf_en_r <= 1'b0;
      temp_en_r <= 1'b0;
      bias_en_r <= 1'b0;
      ref_bias_r <= 1'b0;
    end else if (ce) begin
      src_sel_r <= src_sel_nxt;
      buf_en_r <= buf_en_nxt;
      temp_en_r <= temp_en_nxt;
      bias_en_r <= bias_en_nxt;
      ref_bias_r <= ref_bias_nxt;
    end
  end

  // reference settle tracking and status
  always_comb begin
    ref_state_nxt = ref_state_r;
    settle_cnt_nxt = settle_cnt_r;
    case (ref_state_r)
      VRC_REF_OFF: begin
        settle_cnt_nxt = '0;
        if (buf_en_r) begin
          ref_state_nxt = VRC_REF_SETTLE;
        end
      end
      VRC_REF_SETTLE: begin
        if (!buf_en_r) begin
          ref_state_nxt = VRC_REF_OFF;
          settle_cnt_nxt = '0;
        end else if (settle_cnt_r == vrc_pkg::SETTLE_LAST) begin
          ref_state_nxt = VRC_REF_READY;
        end else begin
          settle_cnt_nxt = settle_cnt_r + 1'b1;
        end
      end
      VRC_REF_READY: begin
        if (!buf_en_r) begin
          ref_state_nxt = VRC_REF_OFF;
          settle_cnt_nxt = '0;
        end
      end
      default: begin
        ref_state_nxt = VRC_REF_OFF;
        settle_cnt_nxt = '0;
      end
    endcase

    // supply and outside reference need no warm-up of the buffer
    if (src_sel_r == vrc_pkg::SRC_SUPPLY) begin
      ready_nxt = 1'b1;
    end else if (buf_en_r) begin
      ready_nxt = (ref_state_nxt == VRC_REF_READY);
    end else begin
      ready_nxt = 1'b1;
    end

    // sensor output is high impedance while off
    temp_valid_nxt = temp_en_r && ref_bias_r;

    // flag a pin 7 setup that would spoil an outside reference
    pin_err_nxt = uses_external_ref(ctrl_r) &&
                  ((port0_input_mode[vrc_pkg::BIT_P0_PIN7] != vrc_pkg::P0_ANALOG_MODE) ||
                   (port0_crossbar_skip[vrc_pkg::BIT_P0_PIN7] != vrc_pkg::P0_SKIPPED));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_state_r <= VRC_REF_OFF;
      settle_cnt_r <= '0;
      ready_r <= 1'b0;
      temp_valid_r <= 1'b0;
      pin_err_r <= 1'b0;
    end else if (ce) begin
      ref_state_r <= ref_state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      ready_r <= ready_nxt;
      temp_valid_r <= temp_valid_nxt;
      pin_err_r <= pin_err_nxt;
    end
  end

  assign ref_source_select = src_sel_r;
  assign ref_buffer_enable = buf_en_r;
  assign temp_sensor_enable = temp_en_r;
  assign bias_gen_enable = bias_en_r;
  assign ref_bias_enable = ref_bias_r;
  assign ref_ready = ready_r;
  assign temp_data_valid = temp_valid_r;
  assign vref_pin_cfg_err = pin_err_r;

endmodule // vrc_top

/* dv/vrc_checker.sv */
// Purpose: port assertions for vrc_top
// Assumes: one clock, reset low active
// Notes: controls lag a taken write by two edges
`timescale 1ns/1ns
module vrc_checker (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // peripherals
  input wire logic adc_enable,
  input wire logic int_osc_enable,
  input wire logic clk_mult_enable,
  // controls and sensor data valid status
  input wire logic ref_source_select,
  input wire logic ref_buffer_enable,
  input wire logic temp_sensor_enable,
  input wire logic bias_gen_enable,
  input wire logic ref_bias_enable,
  input wire logic temp_data_valid
);
  // sampled reset in the antecedents keeps the release edge out of every attempt but sensor_valid_a and upper_zero_a
  wire logic hit = resetn && ce && sfr_wr && (sfr_addr == vrc_pkg::REF_CTRL_ADDR);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  src_select_a:
    assert property (hit ##1 ce |=> ref_source_select == $past(sfr_wdata[3], 2))
    else $error("source select wrong");
  bias_forced_a:
    assert property (resetn && ce && (adc_enable || int_osc_enable) |=> bias_gen_enable)
    else $error("bias not forced");
  bias_manual_a:
    assert property (hit ##1 ce && !adc_enable && !int_osc_enable
      |=> bias_gen_enable == $past(sfr_wdata[1], 2))
    else $error("bias bit ignored");
  ref_bias_auto_a:
    assert property (resetn && ce && clk_mult_enable |=> ref_bias_enable)
    else $error("ref bias not forced");
  ref_bias_reg_a:
    assert property (hit ##1 ce && !clk_mult_enable
      |=> ref_bias_enable == $past(sfr_wdata[0] | sfr_wdata[2], 2))
    else $error("ref bias wrong");
  sensor_enable_a:
    assert property (hit ##1 ce |=> temp_sensor_enable == $past(sfr_wdata[2], 2))
    else $error("sensor enable wrong");
  sensor_valid_a:
    assert property (ce |=> temp_data_valid == $past(temp_sensor_enable && ref_bias_enable))
    else $error("sensor valid wrong");
  upper_zero_a:
    assert property (sfr_rdata[7:4] == 4'h0)
    else $error("upper bits not zero");
  buffer_enable_a:
    assert property (hit ##1 ce |=> ref_buffer_enable == $past(sfr_wdata[0], 2))
    else $error("buffer enable wrong");
endmodule // vrc_checker

bind vrc_top vrc_checker vrc_checker_inst (.clk, .resetn, .ce, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rdata, .adc_enable, .int_osc_enable, .clk_mult_enable,
  .ref_source_select, .ref_buffer_enable, .temp_sensor_enable, .bias_gen_enable,
  .ref_bias_enable, .temp_data_valid);

/* dv/tb.sv */
// Purpose: random and corner stimulus for vrc_top
// Assumes: seed fixed, ce high except one frozen-write corner case
// Notes: expectations come from a register model
`timescale 1ns/1ns
module tb;
  logic clk = 0, resetn = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, ref_ready, temp_data_valid;
  logic ref_source_select, ref_buffer_enable, temp_sensor_enable, bias_gen_enable;
  logic ref_bias_enable, vref_pin_cfg_err;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, port0_input_mode = 0;
  logic [7:0] port0_crossbar_skip = 0, d;
  logic [3:0] reg_m = 0;
  logic [2:0] per = 0;
  integer seed = 48233;
  int fail_count = 0, checks = 0, cyc = 0, n;
  vrc_top vrc_top_inst (.clk, .resetn, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .adc_enable(per[0]), .int_osc_enable(per[1]), .clk_mult_enable(per[2]),
    .port0_input_mode, .port0_crossbar_skip, .ref_source_select, .ref_buffer_enable,
    .temp_sensor_enable, .bias_gen_enable, .ref_bias_enable, .ref_ready,
    .temp_data_valid, .vref_pin_cfg_err);
  always #5 clk = ~clk;
  function automatic logic [7:0] exp_ctl(input logic [3:0] r, input logic [2:0] p,
    input logic m7, input logic s7);
    return {2'h0, r[3], r[0], r[2], r[1] | p[0] | p[1], r[0] | r[2] | p[2],
      ~r[3] & ~r[0] & (m7 | ~s7)};
  endfunction
  task automatic close_out;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    if (a == 8'hD1) reg_m = v[3:0];
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1 chk(sfr_rdata, a == 8'hD1 ? {4'h0, reg_m} : 8'h00);
    chk({7'h0, temp_data_valid}, {7'h0, reg_m[2]});
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 60; i++) begin
      per <= 3'($random(seed));
      port0_input_mode <= 8'($random(seed));
      port0_crossbar_skip <= 8'($random(seed));
      d = (i < 16) ? {4'hA, i[3:0]} : 8'($random(seed));
      wr((i % 7 == 3) ? 8'hD0 : 8'hD1, d);
      @(posedge clk);
      #1 chk({2'h0, ref_source_select, ref_buffer_enable, temp_sensor_enable,
        bias_gen_enable, ref_bias_enable, vref_pin_cfg_err},
        exp_ctl(reg_m, per, port0_input_mode[7], port0_crossbar_skip[7]));
      @(posedge clk);
      rd((i % 5 == 2) ? 8'hD2 : 8'hD1);
    end
    wr(8'hD1, 8'h00);
    @(posedge clk);
    wr(8'hD1, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, ref_ready}, 8'h00);
    n = 0;
    while (ref_ready !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h0, n == vrc_pkg::VREF_TURN_ON_CYC}, 8'h01);
    // write while frozen must leave register and controls alone
    @(posedge clk);
    ce <= 1'b0;
    wr(8'hD1, 8'h0E);
    ce <= 1'b1;
    reg_m = 4'h1;
    @(posedge clk);
    #1 chk({2'h0, ref_source_select, ref_buffer_enable, temp_sensor_enable,
      bias_gen_enable, ref_bias_enable, vref_pin_cfg_err},
      exp_ctl(reg_m, per, port0_input_mode[7], port0_crossbar_skip[7]));
    chk({7'h0, ref_ready}, 8'h01);
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    reg_m = 4'h0;
    @(posedge clk);
    rd(8'hD1);
    close_out();
  end
endmodule // tb
